// ===== rtl/clk_select_pkg.sv
/*
 * Constants, register map and enumerations shared by the modem clock
 * source selector.
 * Assumes a 125 MHz system clock and a 32-bit plain register port.
 */
package clk_select_pkg;
   localparam int CLK_MHZ            = 125;
   localparam int MONITOR_WINDOW_NS  = 2000;
   localparam int MONITOR_WINDOW_CYC = (MONITOR_WINDOW_NS * CLK_MHZ + 999) / 1000;
   localparam int OSC_HALF_CYC       = 32;
   localparam int NUM_SOURCES        = 5;

   localparam logic [7:0]  REG_CONTROL  = 8'h00;
   localparam logic [7:0]  REG_PRIORITY = 8'h04;
   localparam logic [7:0]  REG_STATUS   = 8'h08;
   localparam logic [7:0]  REG_MEASURE  = 8'h0C;

   localparam int CTL_TX_SRC    = 0;
   localparam int CTL_SEND_MODE = 1;
   localparam int CTL_POL_LO    = 2;
   localparam int CTL_FALLBACK  = 4;
   localparam int CTL_TX_LOCK   = 8;
   localparam int CTL_RX_LOCK   = 9;
   localparam logic [31:0] CTL_TX_MASK   = 32'h0000_000F;
   localparam logic [31:0] CTL_RX_MASK   = 32'h0000_0010;
   localparam logic [31:0] CTL_LOCK_MASK = 32'h0000_0300;
   localparam logic [31:0] CONTROL_RST   = 32'h0000_0010;
   localparam logic [14:0] PRIORITY_RST  = 15'h4688;

   localparam int STS_ACTIVE_LO = 0;
   localparam int STS_RX_SRC_LO = 5;
   localparam int STS_OSC_FB    = 8;
   localparam int STS_UNDERFLOW = 9;
   localparam int STS_FIFO_FULL = 10;

   typedef enum logic [2:0] {
      SRC_SAT, SRC_TERR, SRC_SEND, SRC_STATION, SRC_INSERT
   } rx_src_t;

   typedef enum logic [1:0] {
      POL_NORMAL, POL_INVERTED, POL_AUTO, POL_RSVD
   } polarity_t;
endpackage : clk_select_pkg

// ===== rtl/modem_clock_source_select.sv
/*
 * Transmit clock choice with dejitter FIFO and autophase capture, internal
 * send clock generation, and prioritised receive buffer clock selection.
 * Assumes the pin clocks are far slower than clk_sys; they are sampled.
 */
`timescale 1ns/100ps
`default_nettype none
// How it works
// - transmit and receive settings each have their own lock bit
// - transmit source is terrestrial clock or internal send clock
// - terrestrial data goes through a dejitter FIFO read by modulator tick
// - send clock feeds transmit path, receive buffer and terminal pin
// - internal mode follows terrestrial rate; recovered mode follows satellite
// - recovered mode falls to oscillator on satellite loss, returns on activity
// - terminal data follows send clock; capture point is aligned automatically
// - polarity normal, inverted or auto
// - software assigns five ranked receive buffer clock sources
// - default ranking satellite, terrestrial, send, station, insert
// - with fallback, use highest ranked source that shows activity
// - returning activity on a higher rank takes the selection back
// - satellite selection drives buffer clock from recovered clock
// - terrestrial selection drives buffer clock from transmit interface
// - send clock as buffer source is best used in internal mode
module modem_clock_source_select #(
   parameter int WINDOW_CYC = clk_select_pkg::MONITOR_WINDOW_CYC,
   parameter int OSC_HALF   = clk_select_pkg::OSC_HALF_CYC,
   parameter int FIFO_AW    = 4
) (
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        ext_tx_terrestrial_clock,
   input  wire logic        tx_terrestrial_data,
   input  wire logic        recovered_sat_clock,
   input  wire logic        external_station_clock,
   input  wire logic        external_insert_clock,
   output logic             tx_bit,
   output logic             tx_bit_valid,
   output logic             send_timing,
   output logic             rx_buffer_clock,
   output logic      [2:0]  rx_buffer_source
);
   import clk_select_pkg::*;

   localparam int DEPTH = 1 << FIFO_AW;
   localparam logic [FIFO_AW:0] HALF_FILL = (FIFO_AW+1)'(DEPTH / 2);
   localparam logic [FIFO_AW:0] FULL_FILL = (FIFO_AW+1)'(DEPTH);
   localparam logic [15:0] WIN_LAST = 16'(WINDOW_CYC - 1);
   localparam logic [15:0] OSC_H    = 16'(OSC_HALF);

   function automatic logic [FIFO_AW:0] gray2bin(input logic [FIFO_AW:0] g);
      logic [FIFO_AW:0] b;
      b = '0;
      for (int k = FIFO_AW; k >= 0; k--) begin
         b[k] = (k == FIFO_AW) ? g[k] : (b[k+1] ^ g[k]);
      end
      return b;
   endfunction : gray2bin

   // pins: 0 terrestrial clock, 1 satellite, 2 station, 3 insert, 4 data
   logic [4:0] pin_s1_ff, pin_s2_ff, pin_s3_ff;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pin_s1_ff <= 5'h00;
         pin_s2_ff <= 5'h00;
         pin_s3_ff <= 5'h00;
      end else begin
         pin_s1_ff <= {tx_terrestrial_data, external_insert_clock, external_station_clock,
                       recovered_sat_clock, ext_tx_terrestrial_clock};
         pin_s2_ff <= pin_s1_ff;
         pin_s3_ff <= pin_s2_ff;
      end
   end
   wire logic [3:0] clk_edge = pin_s2_ff[3:0] ^ pin_s3_ff[3:0];

   // activity monitors
   logic [3:0] act_ff;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_mon
         logic [15:0] cnt_ff, nxt_cnt;
         logic        nxt_act;
         always_comb begin
            nxt_cnt = cnt_ff + 16'h0001;
            nxt_act = act_ff[gi];
            if (clk_edge[gi]) begin
               nxt_cnt = 16'h0000;
               nxt_act = 1'b1;
            end else if (cnt_ff >= WIN_LAST) begin
               nxt_cnt = WIN_LAST;
               nxt_act = 1'b0;
            end
         end
         always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
               cnt_ff     <= 16'h0000;
               act_ff[gi] <= 1'b0;
            end else begin
               cnt_ff     <= nxt_cnt;
               act_ff[gi] <= nxt_act;
            end
         end
         mon_idle_a: assert property (@(posedge clk_sys) disable iff (!rstn)
            (cnt_ff == WIN_LAST && !clk_edge[gi]) |=> !act_ff[gi])
            else $error("monitor stayed active past window");
         mon_edge_a: assert property (@(posedge clk_sys) disable iff (!rstn)
            clk_edge[gi] |=> act_ff[gi] && cnt_ff == 16'h0000)
            else $error("edge did not restore activity");
      end
   endgenerate
   wire logic [4:0] src_active = {act_ff[3], act_ff[2], 1'b1, act_ff[0], act_ff[1]};

   // register file
   logic [31:0] ctl_ff, nxt_ctl, nxt_rdata;
   logic [14:0] prio_ff, nxt_prio;
   logic        uf_ff, nxt_uf, uf_event, fifo_full, osc_fb_ff;
   logic [2:0]  rx_src_ff;
   logic [15:0] meas_ff;
   wire logic   tx_internal = ctl_ff[CTL_TX_SRC];
   wire logic   send_recov  = ctl_ff[CTL_SEND_MODE];
   wire polarity_t pol      = polarity_t'(ctl_ff[CTL_POL_LO +: 2]);

   always_comb begin
      nxt_ctl   = ctl_ff;
      nxt_prio  = prio_ff;
      nxt_rdata = 32'h0000_0000;
      nxt_uf    = uf_ff;
      if (reg_wr && reg_addr == REG_CONTROL) begin
         nxt_ctl = (ctl_ff & ~CTL_LOCK_MASK) | (reg_wdata & CTL_LOCK_MASK);
         if (!ctl_ff[CTL_TX_LOCK])
            nxt_ctl = (nxt_ctl & ~CTL_TX_MASK) | (reg_wdata & CTL_TX_MASK);
         if (!ctl_ff[CTL_RX_LOCK])
            nxt_ctl = (nxt_ctl & ~CTL_RX_MASK) | (reg_wdata & CTL_RX_MASK);
      end
      if (reg_wr && reg_addr == REG_PRIORITY && !ctl_ff[CTL_RX_LOCK])
         nxt_prio = reg_wdata[14:0];
      if (reg_wr && reg_addr == REG_STATUS && reg_wdata[STS_UNDERFLOW])
         nxt_uf = 1'b0;
      if (uf_event)
         nxt_uf = 1'b1; // a new underflow beats the clear
      if (reg_rd) begin
         unique case (reg_addr)
            REG_CONTROL:  nxt_rdata = ctl_ff & (CTL_TX_MASK | CTL_RX_MASK | CTL_LOCK_MASK);
            REG_PRIORITY: nxt_rdata = {17'h0_0000, prio_ff};
            REG_STATUS:   nxt_rdata = {21'h00_0000, fifo_full, uf_ff, osc_fb_ff,
                                       rx_src_ff, src_active};
            REG_MEASURE:  nxt_rdata = {16'h0000, meas_ff};
            default:      nxt_rdata = 32'h0000_0000;
         endcase
      end
   end
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ctl_ff    <= CONTROL_RST;
         prio_ff   <= PRIORITY_RST;
         uf_ff     <= 1'b0;
         reg_rdata <= 32'h0000_0000;
      end else begin
         ctl_ff    <= nxt_ctl;
         prio_ff   <= nxt_prio;
         uf_ff     <= nxt_uf;
         reg_rdata <= nxt_rdata;
      end
   end
   tx_lock_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (reg_wr && reg_addr == REG_CONTROL && ctl_ff[CTL_TX_LOCK]) |=> $stable(ctl_ff[3:0]))
      else $error("locked transmit setting changed");
   rx_lock_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (reg_wr && ctl_ff[CTL_RX_LOCK]) |=> $stable(prio_ff) && $stable(ctl_ff[CTL_FALLBACK]))
      else $error("locked receive setting changed");

   // send clock generation, terrestrial rate measurement and autophase
   logic [15:0] run_ff, nxt_run, nxt_meas, div_ff, nxt_div, half;
   logic [15:0] phase_ff, nxt_phase, plen_ff, nxt_plen, trans_ff, nxt_trans, target;
   logic        send_clk_ff, nxt_send, send_prev_ff, nxt_osc_fb;
   logic        bit_ff, nxt_bit, valid_ff, nxt_valid, cap;
   wire logic   terr_rise = pin_s2_ff[0] & ~pin_s3_ff[0];
   wire logic   send_rise = send_clk_ff & ~send_prev_ff;
   wire logic   send_fall = ~send_clk_ff & send_prev_ff;
   wire logic   data_chg  = pin_s2_ff[4] ^ pin_s3_ff[4];
   // fifo read side signals, driven below
   logic        mod_tick, fifo_empty, fifo_bit;

   always_comb begin
      nxt_run  = (run_ff == 16'hFFFF) ? run_ff : run_ff + 16'h0001;
      nxt_meas = meas_ff;
      if (terr_rise) begin
         nxt_meas = nxt_run;
         nxt_run  = 16'h0000;
      end
      // internal mode tracks the measured terrestrial bit period
      half = (meas_ff[15:1] == 15'h0000) ? OSC_H : {1'b0, meas_ff[15:1]};
      nxt_osc_fb = send_recov && !act_ff[1];
      if (send_recov)
         half = OSC_H;
      nxt_div  = div_ff + 16'h0001;
      nxt_send = send_clk_ff;
      if (div_ff + 16'h0001 >= half) begin
         nxt_div  = 16'h0000;
         nxt_send = ~send_clk_ff;
      end
      if (send_recov && act_ff[1]) begin
         nxt_div  = 16'h0000;
         nxt_send = pin_s2_ff[1];
      end
      nxt_phase = phase_ff + 16'h0001;
      nxt_plen  = plen_ff;
      if (send_rise) begin
         nxt_phase = 16'h0000;
         nxt_plen  = phase_ff + 16'h0001;
      end
      nxt_trans = data_chg ? phase_ff : trans_ff;
      target = trans_ff + {1'b0, plen_ff[15:1]};
      if (target >= plen_ff)
         target = target - plen_ff;
      unique case (pol)
         POL_NORMAL:   cap = send_fall;
         POL_INVERTED: cap = send_rise;
         default:      cap = (phase_ff == target);
      endcase
      nxt_bit   = bit_ff;
      nxt_valid = 1'b0;
      if (tx_internal && cap) begin
         nxt_bit   = pin_s2_ff[4];
         nxt_valid = 1'b1;
      end else if (!tx_internal && mod_tick && !fifo_empty) begin
         nxt_bit   = fifo_bit;
         nxt_valid = 1'b1;
      end
   end
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         run_ff       <= 16'h0000;
         meas_ff      <= 16'h0000;
         div_ff       <= 16'h0000;
         send_clk_ff  <= 1'b0;
         send_prev_ff <= 1'b0;
         osc_fb_ff    <= 1'b0;
         phase_ff     <= 16'h0000;
         plen_ff      <= 16'h0002;
         trans_ff     <= 16'h0000;
         bit_ff       <= 1'b0;
         valid_ff     <= 1'b0;
      end else begin
         run_ff       <= nxt_run;
         meas_ff      <= nxt_meas;
         div_ff       <= nxt_div;
         send_clk_ff  <= nxt_send;
         send_prev_ff <= send_clk_ff;
         osc_fb_ff    <= nxt_osc_fb;
         phase_ff     <= nxt_phase;
         plen_ff      <= nxt_plen;
         trans_ff     <= nxt_trans;
         bit_ff       <= nxt_bit;
         valid_ff     <= nxt_valid;
      end
   end
   osc_fallback_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (send_recov && !act_ff[1]) |=> osc_fb_ff)
      else $error("oscillator fallback not flagged");
   send_follow_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (send_recov && act_ff[1]) |=> send_clk_ff == $past(pin_s2_ff[1]))
      else $error("send clock not following satellite clock");
   capture_norm_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (tx_internal && pol == POL_NORMAL && send_fall) |=> valid_ff && bit_ff == $past(pin_s2_ff[4]))
      else $error("normal polarity capture missed");

   // dejitter fifo, link side on the terrestrial clock
   logic             fifo_mem [DEPTH];
   logic [FIFO_AW:0] wbin_ff, nxt_wbin, wgray_ff, rgray_ff;
   logic [FIFO_AW:0] rg_s1_ff, rg_s2_ff, wg_s1_ff, wg_s2_ff;
   logic [1:0]       cfg_s1_ff, cfg_s2_ff;
   logic             neg_data_ff, wr_bit, wr_go;

   always_ff @(negedge ext_tx_terrestrial_clock or negedge rstn) begin
      if (!rstn)
         neg_data_ff <= 1'b0;
      else
         neg_data_ff <= tx_terrestrial_data;
   end
   always_comb begin
      wr_bit   = cfg_s2_ff[1] ? neg_data_ff : tx_terrestrial_data;
      wr_go    = !cfg_s2_ff[0] &&
                 ((wbin_ff ^ gray2bin(rg_s2_ff)) != {1'b1, {FIFO_AW{1'b0}}});
      nxt_wbin = wr_go ? wbin_ff + 1'b1 : wbin_ff;
   end
   always_ff @(posedge ext_tx_terrestrial_clock or negedge rstn) begin
      if (!rstn) begin
         cfg_s1_ff <= 2'b00;
         cfg_s2_ff <= 2'b00;
         rg_s1_ff  <= '0;
         rg_s2_ff  <= '0;
         wbin_ff   <= '0;
         wgray_ff  <= '0;
      end else begin
         cfg_s1_ff <= {pol == POL_INVERTED, tx_internal};
         cfg_s2_ff <= cfg_s1_ff;
         rg_s1_ff  <= rgray_ff;
         rg_s2_ff  <= rg_s1_ff;
         wbin_ff   <= nxt_wbin;
         wgray_ff  <= nxt_wbin ^ (nxt_wbin >> 1);
      end
   end
   always_ff @(posedge ext_tx_terrestrial_clock) begin
      if (wr_go)
         fifo_mem[wbin_ff[FIFO_AW-1:0]] <= wr_bit;
   end

   // fifo read side on the modulator tick; the tick period is trimmed by
   // fill level, a small digital loop that locks it to the terrestrial rate
   logic [FIFO_AW:0] rbin_ff, nxt_rbin, fill;
   logic [15:0]      mcnt_ff, nxt_mcnt, limit;
   always_comb begin
      fill       = gray2bin(wg_s2_ff) - rbin_ff;
      fifo_empty = (fill == '0);
      fifo_full  = (fill == FULL_FILL);
      fifo_bit   = fifo_mem[rbin_ff[FIFO_AW-1:0]];
      limit      = meas_ff;
      if (fill > HALF_FILL)
         limit = meas_ff - 16'h0001;
      else if (fill < HALF_FILL)
         limit = meas_ff + 16'h0001;
      mod_tick = (meas_ff != 16'h0000) && (mcnt_ff + 16'h0001 >= limit);
      nxt_mcnt = mod_tick ? 16'h0000 : mcnt_ff + 16'h0001;
      uf_event = !tx_internal && mod_tick && fifo_empty;
      nxt_rbin = (!tx_internal && mod_tick && !fifo_empty) ? rbin_ff + 1'b1 : rbin_ff;
   end
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wg_s1_ff <= '0;
         wg_s2_ff <= '0;
         rbin_ff  <= '0;
         rgray_ff <= '0;
         mcnt_ff  <= 16'h0000;
      end else begin
         wg_s1_ff <= wgray_ff;
         wg_s2_ff <= wg_s1_ff;
         rbin_ff  <= nxt_rbin;
         rgray_ff <= nxt_rbin ^ (nxt_rbin >> 1);
         mcnt_ff  <= nxt_mcnt;
      end
   end
   fifo_read_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (!tx_internal && mod_tick && !fifo_empty) |=> valid_ff && $changed(rbin_ff))
      else $error("modulator tick did not drain fifo");

   // receive buffer clock selection
   logic [2:0] nxt_rx_src, cand;
   logic       rxclk_ff, nxt_rxclk;
   logic [4:0] src_level;
   always_comb begin
      nxt_rx_src = prio_ff[2:0];
      if (ctl_ff[CTL_FALLBACK]) begin
         // scan low rank upward so the highest ranked live source wins
         for (int r = NUM_SOURCES - 1; r >= 0; r--) begin
            cand = prio_ff[3*r +: 3];
            if (cand < 3'(NUM_SOURCES) && src_active[cand])
               nxt_rx_src = cand;
         end
      end
      cand = 3'h0;
      // sampled sources carry clk_sys jitter; a buffer clock, not a data clock
      src_level = {pin_s2_ff[3], pin_s2_ff[2], send_clk_ff, pin_s2_ff[0], pin_s2_ff[1]};
      nxt_rxclk = (rx_src_ff < 3'(NUM_SOURCES)) ? src_level[rx_src_ff] : 1'b0;
   end
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rx_src_ff <= SRC_SAT;
         rxclk_ff  <= 1'b0;
      end else begin
         rx_src_ff <= nxt_rx_src;
         rxclk_ff  <= nxt_rxclk;
      end
   end
   top_rank_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      (ctl_ff[CTL_FALLBACK] && prio_ff[2:0] < 3'(NUM_SOURCES) && src_active[prio_ff[2:0]])
      |=> rx_src_ff == $past(prio_ff[2:0]))
      else $error("live top rank not selected");
   sat_clock_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      rx_src_ff == SRC_SAT |=> rxclk_ff == $past(pin_s2_ff[1]))
      else $error("buffer clock not from satellite clock");
   send_buffer_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      rx_src_ff == SRC_SEND |=> rxclk_ff == $past(send_clk_ff))
      else $error("buffer clock not from send clock");

   assign tx_bit           = bit_ff;
   assign tx_bit_valid     = valid_ff;
   assign send_timing      = send_clk_ff;
   assign rx_buffer_clock  = rxclk_ff;
   assign rx_buffer_source = rx_src_ff;
endmodule : modem_clock_source_select
`default_nettype wire

// ===== tb/modem_clock_source_select_tb.sv
/*
 * Self-checking bench for the clock source selector.
 * Assumes the terminal model and the design package are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module modem_clock_source_select_tb;
   import clk_select_pkg::*;
   localparam int WIN = 64;
   localparam int OSCH = 10;
   logic        clk_sys, rstn, reg_wr, reg_rd, tx_bit, tx_bit_valid;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rd;
   logic        terr_clk, terr_data, sat_clk, sta_clk, ins_clk;
   logic        send_timing, rx_buffer_clock, st_q, rb_q;
   logic [2:0]  rx_buffer_source;
   logic        terr_en, sat_en, sta_en, ins_en, use_send, launch_fall;
   logic [63:0] hist;
   logic [15:0] rx_hist;
   logic [14:0] pr;
   int          fail_count, samples_checked, st_n, rb_n, v_n;

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   initial begin
      sat_clk = 1'b0;
      sta_clk = 1'b0;
      ins_clk = 1'b0;
      fork
         forever #50 if (sat_en) sat_clk = ~sat_clk;
         forever #60 if (sta_en) sta_clk = ~sta_clk;
         forever #68 if (ins_en) ins_clk = ~ins_clk;
      join
   end

   modem_clock_source_select #(.WINDOW_CYC(WIN), .OSC_HALF(OSCH), .FIFO_AW(4)) u_dut (
      .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ext_tx_terrestrial_clock(terr_clk), .tx_terrestrial_data(terr_data),
      .recovered_sat_clock(sat_clk), .external_station_clock(sta_clk),
      .external_insert_clock(ins_clk), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
      .send_timing(send_timing), .rx_buffer_clock(rx_buffer_clock),
      .rx_buffer_source(rx_buffer_source));

   terminal_model u_term (
      .enable(terr_en), .use_send(use_send), .launch_fall(launch_fall),
      .send_timing(send_timing), .ext_tx_terrestrial_clock(terr_clk),
      .tx_terrestrial_data(terr_data), .hist(hist));

   always @(posedge clk_sys) begin
      st_q <= send_timing;
      rb_q <= rx_buffer_clock;
      if (send_timing === 1'b1 && st_q === 1'b0) st_n++;
      if (rx_buffer_clock === 1'b1 && rb_q === 1'b0) rb_n++;
      if (tx_bit_valid === 1'b1) begin
         rx_hist <= {rx_hist[14:0], tx_bit};
         v_n++;
      end
   end

   function automatic logic [2:0] exp_src(logic [14:0] p, logic [4:0] act);
      exp_src = p[2:0];
      for (int i = 4; i >= 0; i--) begin
         if (p[3*i+:3] <= 3'd4) begin
            if (act[p[3*i+:3]]) exp_src = p[3*i+:3];
         end
      end
   endfunction : exp_src

   // a short window can match by chance, so 16 bits are compared
   function automatic logic seen(logic [63:0] h, logic [15:0] r);
      seen = 1'b0;
      for (int k = 0; k <= 40; k++) if (h[k+:16] === r) seen = 1'b1;
   endfunction : seen

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic near(input int got, input int exp, input string what);
      samples_checked++;
      if (got < exp - 2 || got > exp + 2) begin
         fail_count++;
         $display("[ERR] %0t %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask : near

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 rd = reg_rdata;
   endtask : rd_reg

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : wait_cyc

   task automatic measure(input int n);
      wait_cyc(1);
      st_n = 0;
      rb_n = 0;
      v_n  = 0;
      wait_cyc(n);
   endtask : measure

   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : summarize

   initial begin
      #400_000;
      fail_count++;
      $display("[ERR] %0t timeout", $time);
      summarize();
   end

   initial begin
      {rstn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {terr_en, sat_en, sta_en, ins_en, use_send, launch_fall} = 6'b111110;
      rx_hist = '0;
      void'($urandom(32'heabb_9a33));
      repeat (4) @(posedge clk_sys);
      rstn <= 1'b1;
      rd_reg(REG_PRIORITY);
      chk(rd, 32'(PRIORITY_RST), "prio reset");
      wait_cyc(1);
      chk(reg_rdata, 32'h0, "rdata idle");
      wr(8'h14, 32'hffff_ffff);
      rd_reg(8'h14);
      chk(rd, 32'h0, "unmapped");
      rd_reg(REG_CONTROL);
      chk(rd, CONTROL_RST, "ctl reset");
      wait_cyc(WIN + 40);
      rd_reg(REG_STATUS);
      chk(32'(rd[4:0]), 32'h1f, "all active");
      chk(32'(rd[7:5]), 32'(SRC_SAT), "sts source");
      chk(32'(rx_buffer_source), 32'(SRC_SAT), "sat first");
      measure(400);
      near(rb_n, 32, "sat rate");
      sat_en = 1'b0;
      wait_cyc(WIN + 40);
      chk(32'(rx_buffer_source), 32'(SRC_TERR), "to terr");
      measure(400);
      near(rb_n, 50, "terr rate");
      rd_reg(REG_MEASURE);
      chk(32'(rd[15:0]), 32'h8, "terr period");
      terr_en = 1'b0;
      wait_cyc(WIN + 40);
      chk(32'(rx_buffer_source), 32'(SRC_SEND), "to send");
      measure(400);
      near(rb_n, 50, "send buffer rate");
      wr(REG_CONTROL, 32'h0);
      wait_cyc(4);
      chk(32'(rx_buffer_source), 32'(SRC_SAT), "no fallback");
      wr(REG_CONTROL, CONTROL_RST);
      {sat_en, terr_en} = 2'b11;
      wait_cyc(20);
      chk(32'(rx_buffer_source), 32'(SRC_SAT), "restore");
      // locks
      wr(REG_CONTROL, 32'h0000_0210);
      wr(REG_CONTROL, 32'h0000_0201);
      wr(REG_PRIORITY, 32'h0000_0000);
      rd_reg(REG_CONTROL);
      chk(rd, 32'h0000_0211, "rx lock");
      rd_reg(REG_PRIORITY);
      chk(rd, 32'(PRIORITY_RST), "prio locked");
      wr(REG_CONTROL, 32'h0000_0311);
      wr(REG_CONTROL, 32'h0000_0302);
      rd_reg(REG_CONTROL);
      chk(rd, 32'h0000_0311, "tx lock");
      wr(REG_CONTROL, 32'h0);
      wr(REG_CONTROL, CONTROL_RST);
      for (int i = 0; i < 12; i++) begin
         for (int j = 0; j < 5; j++) pr[3*j+:3] = 3'($urandom_range(0, 5));
         pr[3*$urandom_range(0, 4)+:3] = 3'd2;
         {sat_en, terr_en, sta_en, ins_en} = (i < 2) ? 4'h0 : 4'($urandom);
         wr(REG_PRIORITY, 32'(pr));
         wait_cyc(WIN + 40);
         chk(32'(rx_buffer_source), 32'(exp_src(pr, {ins_en, sta_en, 1'b1, terr_en, sat_en})),
             "rank pick");
         rd_reg(REG_PRIORITY);
         chk(rd, 32'(pr), "prio rw");
      end
      {sat_en, terr_en, sta_en, ins_en} = 4'hf;
      wr(REG_PRIORITY, 32'(PRIORITY_RST));
      for (int p = 0; p < 4; p++) begin
         launch_fall = (p == 1);
         wr(REG_CONTROL, 32'h11 | 32'(p << 2));
         wait_cyc(200);
         measure(400);
         near(v_n, 50, "send bits");
         near(st_n, 50, "send pin");
         chk(32'(seen(hist, rx_hist)), 32'h1, "send data");
      end
      launch_fall = 1'b0;
      wr(REG_CONTROL, 32'h0000_001b);
      wait_cyc(100);
      measure(400);
      near(st_n, 32, "recov rate");
      chk(32'(seen(hist, rx_hist)), 32'h1, "recov data");
      sat_en = 1'b0;
      wait_cyc(WIN + 40);
      rd_reg(REG_STATUS);
      chk(32'(rd[STS_OSC_FB]), 32'h1, "on osc");
      measure(400);
      near(st_n, 400 / (2 * OSCH), "osc rate");
      sat_en = 1'b1;
      wait_cyc(20);
      rd_reg(REG_STATUS);
      chk(32'(rd[STS_OSC_FB]), 32'h0, "back to sat");
      use_send = 1'b0;
      wr(REG_CONTROL, 32'h0000_0010);
      // from empty the fill climbs about one bit per 72 cycles
      wait_cyc(900);
      wr(REG_STATUS, 32'h0000_0200);
      measure(400);
      near(v_n, 50, "fifo rate");
      chk(32'(seen(hist, rx_hist)), 32'h1, "fifo data");
      rd_reg(REG_STATUS);
      chk(32'(rd[STS_UNDERFLOW]), 32'h0, "underflow");
      chk(32'(rd[STS_FIFO_FULL]), 32'h0, "fifo full");
      summarize();
   end
endmodule : modem_clock_source_select_tb
`default_nettype wire

// ===== tb/terminal_model.sv
/*
 * Terrestrial terminal model: link clock and data toward the selector.
 * Assumes the bench gates its clock and picks the launch edge.
 */
`timescale 1ns/100ps
`default_nettype none
module terminal_model (
   input  wire logic        enable,
   input  wire logic        use_send,
   input  wire logic        launch_fall,
   input  wire logic        send_timing,
   output logic             ext_tx_terrestrial_clock,
   output logic             tx_terrestrial_data,
   output logic      [63:0] hist
);
   logic [15:0] lfsr;
   task automatic launch();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      tx_terrestrial_data = lfsr[0];
      hist = {hist[62:0], lfsr[0]};
   endtask : launch
   initial begin
      lfsr = 16'hace1;
      hist = '0;
      tx_terrestrial_data = 1'b0;
      ext_tx_terrestrial_clock = 1'b0;
      #5;
      // clock stands still while disabled
      forever #32 if (enable) ext_tx_terrestrial_clock = ~ext_tx_terrestrial_clock;
   end
   // launch away from the edge that samples
   always @(negedge ext_tx_terrestrial_clock) if (!use_send) launch();
   always @(posedge send_timing) if (use_send && !launch_fall) launch();
   always @(negedge send_timing) if (use_send && launch_fall) launch();
endmodule : terminal_model
`default_nettype wire
